// ===== rtl/smw_pkg.sv
package smw_pkg;

    // Controller register port width and register offsets
    localparam int unsigned        SMW_REG_AW      = 12;
    localparam logic [11:0]        SMW_OFF_BASE0   = 12'h104;
    localparam logic [11:0]        SMW_OFF_RDLIM0  = 12'h108;
    localparam logic [11:0]        SMW_OFF_WRLIM0  = 12'h10A;
    localparam logic [11:0]        SMW_OFF_BASE1   = 12'h10C;
    localparam logic [11:0]        SMW_OFF_RDLIM1  = 12'h110;
    localparam logic [11:0]        SMW_OFF_WRLIM1  = 12'h112;
    localparam logic [11:0]        SMW_OFF_STATUS  = 12'h120;

    // Field layout: base in 31:2, ceilings in 14:2, region select in offset bit 15
    localparam int unsigned        SMW_BASE_LSB    = 2;
    localparam int unsigned        SMW_BASE_W      = 30;
    localparam int unsigned        SMW_LIM_LSB     = 2;
    localparam int unsigned        SMW_LIM_W       = 13;
    localparam int unsigned        SMW_SEL_BIT     = 15;
    localparam int unsigned        SMW_OFF_W       = 16;

    // Reset values
    localparam logic [29:0]        SMW_BASE_RST    = 30'h00000000;
    localparam logic [12:0]        SMW_LIM_RST     = 13'h0000;
    localparam logic [15:0]        SMW_WOFF_RST    = 16'h0000;
    localparam logic [31:0]        SMW_DATA_RST    = 32'h00000000;

    // Read path latency of the internal memory, in cycles
    localparam int unsigned        SMW_MEM_LAT     = 1;

    // Window engine states
    typedef enum logic [1:0] {
        SMW_IDLE,
        SMW_ISSUE,
        SMW_CAPTURE
    } smw_state_type;

    // Request toward internal memory
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } smw_mem_req_type;

    localparam smw_mem_req_type SMW_MEM_IDLE = '{1'b0, 1'b0, 32'h00000000, 4'h0, 32'h00000000};

endpackage : smw_pkg

// ===== rtl/smw_region_gate.sv
`timescale 1ns/1ps
`default_nettype none

module smw_region_gate import smw_pkg::*; (
    // Access selection
    input  wire logic [12:0] word_off,
    input  wire logic        region_sel,
    // Region settings
    input  wire logic [29:0] base0,
    input  wire logic [29:0] base1,
    input  wire logic [12:0] ceil0,
    input  wire logic [12:0] ceil1,
    // Verdict
    output logic             allow,
    output logic [31:0]      addr
);

    logic [29:0] base_sel;
    logic [12:0] ceil_sel;

    // Region select picks base and ceiling
    always_comb begin
        base_sel = region_sel ? base1 : base0;
        ceil_sel = region_sel ? ceil1 : ceil0;
    end

    // Strictly below ceiling passes; start plus word offset
    always_comb begin
        allow = (word_off < ceil_sel);
        addr  = {base_sel, 2'b00} + {17'h00000, word_off, 2'b00};
    end

endmodule : smw_region_gate

`default_nettype wire

// ===== rtl/smw_window_limits.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - region 0 read only below read ceiling
// - region 0 write only below write ceiling
// - region 1 start from base bits 31:2
// - region 1 target is base plus offset
// - region 1 read only below read ceiling
// - region 0 target is base plus offset
// - region 1 write only below write ceiling
module smw_window_limits import smw_pkg::*; (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Controller register port
    input  wire logic [SMW_REG_AW-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    // Host offset register
    input  wire logic                  host_off_wr,
    input  wire logic [15:0]           host_off_wdata,
    output logic      [15:0]           host_off_rdata,
    // Host data port
    input  wire logic                  host_data_rd,
    input  wire logic                  host_data_wr,
    input  wire logic [3:0]            host_data_be,
    input  wire logic [31:0]           host_data_wdata,
    output logic      [31:0]           host_data_rdata,
    output logic                       host_rd_done,
    output logic                       host_busy,
    // Internal memory port
    output smw_mem_req_type            mem_req,
    input  wire logic [31:0]           mem_rdata
);

    // Reset release chain
    logic                  rst_meta;
    logic                  rst_n;

    // Register file
    logic [29:0]           base0;
    logic [29:0]           base1;
    logic [12:0]           ceil_r0;
    logic [12:0]           ceil_w0;
    logic [12:0]           ceil_r1;
    logic [12:0]           ceil_w1;
    logic [29:0]           next_base0;
    logic [29:0]           next_base1;
    logic [12:0]           next_ceil_r0;
    logic [12:0]           next_ceil_w0;
    logic [12:0]           next_ceil_r1;
    logic [12:0]           next_ceil_w1;
    logic [31:0]           next_reg_rdata;

    // Window engine
    smw_state_type         state;
    smw_state_type         next_state;
    logic [15:0]           window_offset_register;
    logic [15:0]           next_window_offset_register;
    logic [31:0]           window_data_port;
    logic [31:0]           next_window_data_port;
    logic                  next_rd_done;
    logic                  next_busy;
    smw_mem_req_type       next_mem_req;
    logic                  last_rd_blocked;
    logic                  last_wr_blocked;
    logic                  next_last_rd_blocked;
    logic                  next_last_wr_blocked;

    // Gate verdicts
    logic                  rd_allow;
    logic                  wr_allow;
    logic [31:0]           rd_addr;
    logic [31:0]           wr_addr;
    logic                  window_offset_high_field;
    logic [12:0]           word_off;

    // Release reset through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Offset fields
    always_comb begin
        window_offset_high_field = window_offset_register[SMW_SEL_BIT];
        word_off                 = window_offset_register[14:2];
    end

    smw_region_gate u_rd_gate (
        .word_off   (word_off),
        .region_sel (window_offset_high_field),
        .base0      (base0),
        .base1      (base1),
        .ceil0      (ceil_r0),
        .ceil1      (ceil_r1),
        .allow      (rd_allow),
        .addr       (rd_addr)
    );

    smw_region_gate u_wr_gate (
        .word_off   (word_off),
        .region_sel (window_offset_high_field),
        .base0      (base0),
        .base1      (base1),
        .ceil0      (ceil_w0),
        .ceil1      (ceil_w1),
        .allow      (wr_allow),
        .addr       (wr_addr)
    );

    // Controller register writes and reads
    always_comb begin
        next_base0     = base0;
        next_base1     = base1;
        next_ceil_r0   = ceil_r0;
        next_ceil_w0   = ceil_w0;
        next_ceil_r1   = ceil_r1;
        next_ceil_w1   = ceil_w1;
        next_reg_rdata = 32'h00000000;
        if (reg_wr) begin
            case (reg_addr)
                SMW_OFF_BASE0:  next_base0   = reg_wdata[31:2];
                SMW_OFF_RDLIM0: next_ceil_r0 = reg_wdata[14:2];
                SMW_OFF_WRLIM0: next_ceil_w0 = reg_wdata[14:2];
                SMW_OFF_BASE1:  next_base1   = reg_wdata[31:2];
                SMW_OFF_RDLIM1: next_ceil_r1 = reg_wdata[14:2];
                SMW_OFF_WRLIM1: next_ceil_w1 = reg_wdata[14:2];
                default:        next_base0   = base0;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                SMW_OFF_BASE0:  next_reg_rdata = {base0, 2'b00};
                SMW_OFF_RDLIM0: next_reg_rdata = {17'h00000, ceil_r0, 2'b00};
                SMW_OFF_WRLIM0: next_reg_rdata = {17'h00000, ceil_w0, 2'b00};
                SMW_OFF_BASE1:  next_reg_rdata = {base1, 2'b00};
                SMW_OFF_RDLIM1: next_reg_rdata = {17'h00000, ceil_r1, 2'b00};
                SMW_OFF_WRLIM1: next_reg_rdata = {17'h00000, ceil_w1, 2'b00};
                SMW_OFF_STATUS: next_reg_rdata = {13'h0000, last_wr_blocked, last_rd_blocked,
                                                  host_busy, window_offset_register};
                default:        next_reg_rdata = 32'h00000000;
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            base0     <= SMW_BASE_RST;
            base1     <= SMW_BASE_RST;
            ceil_r0   <= SMW_LIM_RST;
            ceil_w0   <= SMW_LIM_RST;
            ceil_r1   <= SMW_LIM_RST;
            ceil_w1   <= SMW_LIM_RST;
            reg_rdata <= SMW_DATA_RST;
        end else begin
            base0     <= next_base0;
            base1     <= next_base1;
            ceil_r0   <= next_ceil_r0;
            ceil_w0   <= next_ceil_w0;
            ceil_r1   <= next_ceil_r1;
            ceil_w1   <= next_ceil_w1;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Window engine: host offset, data port, memory requests
    always_comb begin
        next_state                  = state;
        next_window_offset_register = window_offset_register;
        next_window_data_port       = window_data_port;
        next_rd_done                = 1'b0;
        next_mem_req                = SMW_MEM_IDLE;
        next_last_rd_blocked        = last_rd_blocked;
        next_last_wr_blocked        = last_wr_blocked;
        if (host_off_wr) begin
            next_window_offset_register = host_off_wdata;
        end
        case (state)
            SMW_IDLE: begin
                if (host_data_rd) begin
                    if (rd_allow) begin
                        next_mem_req.req  = 1'b1;
                        next_mem_req.addr = rd_addr;
                        next_mem_req.be   = 4'hF;
                        next_state        = SMW_ISSUE;
                    end else begin
                        next_rd_done = 1'b1;
                    end
                    next_last_rd_blocked = !rd_allow;
                end else if (host_data_wr) begin
                    for (int i = 0; i < 4; i++) begin
                        if (host_data_be[i]) begin
                            next_window_data_port[8*i +: 8] = host_data_wdata[8*i +: 8];
                        end
                    end
                    if (wr_allow) begin
                        next_mem_req.req   = 1'b1;
                        next_mem_req.we    = 1'b1;
                        next_mem_req.addr  = wr_addr;
                        next_mem_req.be    = host_data_be;
                        next_mem_req.wdata = host_data_wdata;
                    end
                    next_last_wr_blocked = !wr_allow;
                end
            end
            SMW_ISSUE: begin
                next_state = SMW_CAPTURE;
            end
            SMW_CAPTURE: begin
                next_window_data_port = mem_rdata;
                next_rd_done          = 1'b1;
                next_state            = SMW_IDLE;
            end
            default: begin
                next_state = SMW_IDLE;
            end
        endcase
        next_busy = (next_state != SMW_IDLE);
    end

    // Window engine storage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state                  <= SMW_IDLE;
            window_offset_register <= SMW_WOFF_RST;
            window_data_port       <= SMW_DATA_RST;
            host_rd_done           <= 1'b0;
            host_busy              <= 1'b0;
            mem_req                <= SMW_MEM_IDLE;
            last_rd_blocked        <= 1'b0;
            last_wr_blocked        <= 1'b0;
        end else begin
            state                  <= next_state;
            window_offset_register <= next_window_offset_register;
            window_data_port       <= next_window_data_port;
            host_rd_done           <= next_rd_done;
            host_busy              <= next_busy;
            mem_req                <= next_mem_req;
            last_rd_blocked        <= next_last_rd_blocked;
            last_wr_blocked        <= next_last_wr_blocked;
        end
    end

    // Host-facing copies
    always_comb begin
        host_off_rdata  = window_offset_register;
        host_data_rdata = window_data_port;
    end

    // Checker helpers: expected targets per region
    logic [31:0] chk_addr0;
    logic [31:0] chk_addr1;
    logic        chk_rd_go;
    logic        chk_wr_go;

    always_comb begin
        chk_addr0 = {base0, 2'b00} + {17'h00000, window_offset_register[14:2], 2'b00};
        chk_addr1 = {base1, 2'b00} + {17'h00000, window_offset_register[14:2], 2'b00};
        chk_rd_go = host_data_rd && (state == SMW_IDLE);
        chk_wr_go = host_data_wr && !host_data_rd && (state == SMW_IDLE);
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_rd0_grant;
        chk_rd_go && !window_offset_register[15] && (window_offset_register[14:2] < ceil_r0)
        |=> mem_req.req && !mem_req.we ##2 host_rd_done;
    endproperty
    a_rd0_grant: assert property (p_rd0_grant) else $error("region 0 read not fetched");

    property p_rd0_block;
        chk_rd_go && !window_offset_register[15] && (window_offset_register[14:2] >= ceil_r0)
        |=> !mem_req.req && host_rd_done && $stable(host_data_rdata);
    endproperty
    a_rd0_block: assert property (p_rd0_block) else $error("region 0 read passed ceiling");

    property p_wr0;
        chk_wr_go && !window_offset_register[15] && (window_offset_register[14:2] < ceil_w0)
        |=> mem_req.req && mem_req.we && (mem_req.be == $past(host_data_be));
    endproperty
    a_wr0: assert property (p_wr0) else $error("region 0 write not issued");

    property p_wr1_block;
        chk_wr_go && window_offset_register[15] && (window_offset_register[14:2] >= ceil_w1)
        |=> !mem_req.req;
    endproperty
    a_wr1_block: assert property (p_wr1_block) else $error("region 1 write passed ceiling");

    property p_rd1_block;
        chk_rd_go && window_offset_register[15] && (window_offset_register[14:2] >= ceil_r1)
        |=> !mem_req.req && host_rd_done && $stable(host_data_rdata);
    endproperty
    a_rd1_block: assert property (p_rd1_block) else $error("region 1 read passed ceiling");

    property p_addr1;
        chk_rd_go && window_offset_register[15] && (window_offset_register[14:2] < ceil_r1)
        |=> mem_req.req && (mem_req.addr == $past(chk_addr1));
    endproperty
    a_addr1: assert property (p_addr1) else $error("region 1 address wrong");

    property p_addr0;
        chk_wr_go && !window_offset_register[15] && (window_offset_register[14:2] < ceil_w0)
        |=> mem_req.addr == $past(chk_addr0);
    endproperty
    a_addr0: assert property (p_addr0) else $error("region 0 address wrong");

    property p_rst_ceil;
        $rose(rst_n) |-> (ceil_r0 == 13'h0000) && (ceil_w0 == 13'h0000)
                         && (ceil_r1 == 13'h0000) && (ceil_w1 == 13'h0000) && !mem_req.req;
    endproperty
    a_rst_ceil: assert property (p_rst_ceil) else $error("ceilings not cleared at reset");

    property p_base1;
        reg_wr && (reg_addr == SMW_OFF_BASE1) |=> base1 == $past(reg_wdata[31:2]);
    endproperty
    a_base1: assert property (p_base1) else $error("region 1 start not stored");

endmodule : smw_window_limits

`default_nettype wire

// ===== sim/smw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module smw_mem_model import smw_pkg::*; (
    // Clock
    input  wire logic            ref_clk,
    // Request from the window
    input  wire smw_mem_req_type mem_req,
    // Read data back
    output logic      [31:0]     mem_rdata
);
    // Known pattern for a read, inverse of last value otherwise
    initial mem_rdata = 32'h00000000;
    always @(posedge ref_clk) begin
        if (mem_req.req && !mem_req.we) begin
            mem_rdata <= mem_req.addr ^ 32'hA5A50F0F;
        end else begin
            mem_rdata <= ~mem_rdata; // Stale data never looks valid
        end
    end
endmodule : smw_mem_model

`default_nettype wire

// ===== sim/tb_smw_window_limits.sv
`timescale 1ns/1ps
`default_nettype none

module tb_smw_window_limits import smw_pkg::*;;
    logic            ref_clk = 1'b0;
    logic            arst_n = 1'b0;
    logic [11:0]     reg_addr = 12'h000;
    logic [31:0]     reg_wdata = 32'h00000000;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [31:0]     reg_rdata;
    logic            host_off_wr = 1'b0;
    logic [15:0]     host_off_wdata = 16'h0000;
    logic [15:0]     host_off_rdata;
    logic            host_data_rd = 1'b0;
    logic            host_data_wr = 1'b0;
    logic [3:0]      host_data_be = 4'h0;
    logic [31:0]     host_data_wdata = 32'h00000000;
    logic [31:0]     host_data_rdata;
    logic            host_rd_done;
    logic            host_busy;
    smw_mem_req_type mem_req;
    logic [31:0]     mem_rdata;
    // Bench state
    int              mismatches = 0;
    int              compares = 0;
    int              seed = 32'hd2bc;
    logic [31:0]     reg_q[$];
    logic [31:0]     dat_q[$];
    smw_mem_req_type mem_q[$];
    logic            reg_rd_d = 1'b0;
    logic [15:0]     off = 16'h0000;
    logic [31:0]     dp = 32'h00000000;
    logic [29:0]     bs[2];
    logic [12:0]     rc[2];
    logic [12:0]     wc[2];

    // Clock at 25 MHz
    always #20 ref_clk = ~ref_clk;

    smw_window_limits dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_off_wr(host_off_wr),
        .host_off_wdata(host_off_wdata), .host_off_rdata(host_off_rdata),
        .host_data_rd(host_data_rd), .host_data_wr(host_data_wr), .host_data_be(host_data_be),
        .host_data_wdata(host_data_wdata), .host_data_rdata(host_data_rdata),
        .host_rd_done(host_rd_done), .host_busy(host_busy), .mem_req(mem_req),
        .mem_rdata(mem_rdata)
    );

    smw_mem_model mem (
        .ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata)
    );

    // Comparison with report
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Watchdog
    initial begin
        #(40 * 20000);
        mismatches++;
        stop_test();
    end

    // Output monitor: oldest note against each result
    always @(posedge ref_clk) begin
        smw_mem_req_type e;
        logic [31:0]     m;
        reg_rd_d <= reg_rd;
        if (reg_rd_d === 1'b1) begin
            chk(reg_rdata, reg_q.pop_front());
        end
        if (host_rd_done === 1'b1) begin
            chk(host_data_rdata, dat_q.pop_front());
        end
        if (mem_req.req === 1'b1) begin
            if (mem_q.size() == 0) begin
                chk({31'h0, mem_req.we, mem_req.addr}, 64'hFFFFFFFFFFFFFFFF);
            end else begin
                e = mem_q.pop_front();
                m = e.we ? {{8{e.be[3]}}, {8{e.be[2]}}, {8{e.be[1]}}, {8{e.be[0]}}} : 32'h0;
                chk({27'h0, mem_req.we, mem_req.be, mem_req.addr}, {27'h0, e.we, e.be, e.addr});
                chk({32'h0, mem_req.wdata & m}, {32'h0, e.wdata & m});
            end
        end
    end

    // Register port write
    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Register port read with expected value noted
    task automatic reg_read(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        reg_q.push_back(exp);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : reg_read

    // Window offset write
    task automatic set_off(input logic [15:0] o);
        @(posedge ref_clk);
        host_off_wr <= 1'b1;
        host_off_wdata <= o;
        off = o;
        @(posedge ref_clk);
        host_off_wr <= 1'b0;
        #1;
        chk({48'h0, host_off_rdata}, {48'h0, o});
    endtask : set_off

    // Target address of the current offset
    function automatic logic [31:0] tgt();
        return {bs[off[15]], 2'b00} + {17'h0, off[14:2], 2'b00};
    endfunction : tgt

    // Host read of the data port, bounded wait for done
    task automatic host_read();
        int   n;
        logic ok;
        n = 0;
        ok = off[14:2] < rc[off[15]];
        if (ok) begin
            mem_q.push_back('{1'b1, 1'b0, tgt(), 4'hF, 32'h00000000});
            dp = tgt() ^ 32'hA5A50F0F;
        end
        dat_q.push_back(dp);
        @(posedge ref_clk);
        host_data_rd <= 1'b1;
        @(posedge ref_clk);
        host_data_rd <= 1'b0;
        #1;
        chk({63'h0, host_busy}, {63'h0, ok});
        do begin
            #1;
            if (host_rd_done !== 1'b1) @(posedge ref_clk);
            n++;
        end while (host_rd_done !== 1'b1 && n < 8);
        if (n >= 8) chk(64'h0, 64'h1);
        @(posedge ref_clk);
    endtask : host_read

    // Host write of the data port
    task automatic host_write(input logic [3:0] be, input logic [31:0] d);
        if (off[14:2] < wc[off[15]]) mem_q.push_back('{1'b1, 1'b1, tgt(), be, d});
        for (int i = 0; i < 4; i++) if (be[i]) dp[8*i +: 8] = d[8*i +: 8];
        @(posedge ref_clk);
        host_data_wr <= 1'b1;
        host_data_be <= be;
        host_data_wdata <= d;
        @(posedge ref_clk);
        host_data_wr <= 1'b0;
    endtask : host_write

    // Main sequence
    initial begin
        logic [31:0] v;
        bs = '{30'h0, 30'h0};
        rc = '{13'h0, 13'h0};
        wc = '{13'h0, 13'h0};
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Reset values and blocked window
        reg_read(SMW_OFF_BASE0, 32'h0);
        reg_read(SMW_OFF_RDLIM0, 32'h0);
        reg_read(SMW_OFF_WRLIM0, 32'h0);
        reg_read(SMW_OFF_BASE1, 32'h0);
        reg_read(SMW_OFF_RDLIM1, 32'h0);
        set_off(16'h0000);
        host_read();
        host_write(4'hF, 32'h12345678);
        set_off(16'h8000);
        host_read();
        host_write(4'h3, $random(seed));
        $display("test reset_block done");
        // Unmapped place reads 0 and ignores writes
        reg_write(12'h200, 32'hFFFFFFFF);
        reg_read(12'h200, 32'h0);
        $display("test unmapped done");
        // Both regions: boundary of each ceiling
        for (int r = 0; r < 2; r++) begin
            v = $random(seed);
            bs[r] = v[31:2];
            reg_write(r ? SMW_OFF_BASE1 : SMW_OFF_BASE0, v);
            reg_read(r ? SMW_OFF_BASE1 : SMW_OFF_BASE0, {v[31:2], 2'b00});
            v = $random(seed) | 32'h4;
            rc[r] = v[14:2];
            reg_write(r ? SMW_OFF_RDLIM1 : SMW_OFF_RDLIM0, v);
            reg_read(r ? SMW_OFF_RDLIM1 : SMW_OFF_RDLIM0, {17'h0, v[14:2], 2'b00});
            v = $random(seed) | 32'h4;
            wc[r] = v[14:2];
            reg_write(r ? SMW_OFF_WRLIM1 : SMW_OFF_WRLIM0, v);
            v = $random(seed);
            set_off({r[0], rc[r] - 13'h1, v[1:0]});
            host_read();
            set_off({r[0], rc[r], v[1:0]});
            host_read();
            set_off({r[0], wc[r] - 13'h1, 2'b00});
            host_write(v[3:0] | 4'h1, $random(seed));
            host_write(4'hF, $random(seed));
            set_off({r[0], wc[r], 2'b00});
            host_write(4'hC, $random(seed));
            host_read();
            set_off({r[0], 15'h7FFF});
            host_read();
            // Status: last write and last read refused, idle, offset
            reg_read(SMW_OFF_STATUS, {13'h0, 1'b1, 1'b1, 1'b0, off});
            $display("test region %0d done", r);
        end
        // Mid-run reset clears every setting
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        off = 16'h0000;
        dp  = 32'h00000000;
        rc  = '{13'h0, 13'h0};
        reg_read(SMW_OFF_RDLIM1, 32'h0);
        reg_read(SMW_OFF_STATUS, 32'h0);
        host_read();
        $display("test mid_reset done");
        repeat (4) @(posedge ref_clk);
        chk({32'h0, mem_q.size()}, 64'h0);
        stop_test();
    end
endmodule : tb_smw_window_limits

`default_nettype wire
